// [src/seap_pkg.sv]
package seap_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MS = 10;
  localparam int NS_PER_MS = 1_000_000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int PROG_CW = 24;
  localparam int SCL_FREQ_KHZ = 100;
  localparam int NS_PER_KHZ_PERIOD = 1_000_000;
  localparam int SCL_QTR_CYCLES = NS_PER_KHZ_PERIOD / SCL_FREQ_KHZ / (4 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // protocol values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MEM_ACCESS = 8'h17;
  localparam logic [3:0] DEV_FAMILY = 4'h5; // arbitrary value, fixed bus address prefix
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int MEM_DEPTH = 256;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_DEV, K_CMD, K_MADR, K_DATA} seap_kind_t;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK} seap_dst_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} seap_hst_t;
  typedef enum logic [2:0] {S_DEV0, S_CMD, S_MADR, S_WDATA, S_DEV1, S_RDATA} seap_step_t;
endpackage

// [src/seap_bus_if.sv]
`timescale 1ns/1ps
// open-drain two-wire bus; a driver with its enable high and output low pulls the wire low
interface seap_bus_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // ----------------------------------------------------------------
  // wired-and resolution, pull-ups give a high when nobody drives
  // ----------------------------------------------------------------
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// [src/seap_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module seap_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } seap_sync_t;
  seap_sync_t s;
  seap_sync_t next_s;

  // ----------------------------------------------------------------
  // only the second stage is visible outside
  // ----------------------------------------------------------------
  always_comb begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  // idle bus level is high, so reset to ones to avoid a false start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;
endmodule // seap_sync

// [src/seap_device.sv]
`timescale 1ns/1ps
module seap_device #(
  parameter int unsigned PROG_CYCLES = seap_pkg::PROG_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  seap_bus_if.device bus,
  input wire logic chip_select_bit0_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit2_i,
  output logic busy_o
);
  import seap_pkg::*;

  typedef struct packed {
    seap_dst_t st;
    seap_kind_t kind;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] addr;
    logic [7:0] base;
    logic [2:0] pos;
    logic [3:0] cnt;
    logic wr_open;
    logic tx_next;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic busy;
    logic [3:0] pidx;
    logic [PROG_CW-1:0] pcnt;
    logic [7:0][7:0] wbuf;
  } seap_dev_t;

  seap_dev_t s;
  seap_dev_t next_s;
  logic [4:0] pins;
  logic scl;
  logic sda;
  logic [2:0] cs;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] mem_rd;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  seap_sync #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i, bus.sda, bus.scl}),
    .q_o(pins)
  );

  // edge and condition detect on the synchronised levels
  always_comb begin
    scl = pins[0];
    sda = pins[1];
    cs = pins[4:2];
    rise = scl && !s.scl_q;
    fall = !scl && s.scl_q;
    start_c = scl && s.scl_q && s.sda_q && !sda;
    stop_c = scl && s.scl_q && !s.sda_q && sda;
  end

  // ----------------------------------------------------------------
  // memory array, written one byte per cycle while programming
  // ----------------------------------------------------------------
  always_comb begin
    mem_rd = mem[s.addr];
    mem_we = s.busy && (s.pidx < s.cnt);
    mem_wa = s.base + {5'h0_0, s.pidx[2:0]};
    mem_wd = s.wbuf[s.pidx[2:0]];
  end

  // contents are nonvolatile, so no reset
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // protocol engine and programming timer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    // programming runs beside the bus engine so polling stays possible
    if (s.busy) begin
      if (s.pidx < BUF_DEPTH) begin
        next_s.pidx = s.pidx + ONE4;
      end
      if (s.pcnt == PROG_CW'(PROG_CYCLES - 1)) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.pcnt = s.pcnt + 1'b1;
      end
    end
    if (start_c) begin
      if (s.wr_open) begin
        next_s.cnt = '0;
      end
      next_s.wr_open = 1'b0;
      next_s.st = D_RX;
      next_s.kind = K_DEV;
      next_s.bits = '0;
      next_s.sda_oe = 1'b0;
    end else if (stop_c) begin
      if (s.wr_open) begin
        next_s.busy = 1'b1;
        next_s.pidx = '0;
        next_s.pcnt = '0;
      end
      next_s.wr_open = 1'b0;
      next_s.st = D_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        D_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        D_RX: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], sda};
            next_s.bits = s.bits + ONE4;
          end else if (fall && s.bits == BITS_PER_BYTE) begin
            // unmatched or refused bytes leave sda released and wait for a start
            next_s.st = D_IDLE;
            next_s.tx_next = 1'b0;
            unique case (s.kind)
              K_DEV: begin
                if (s.sh[7:1] == {DEV_FAMILY, cs}) begin
                  next_s.st = D_RX_ACK;
                  next_s.sda_oe = 1'b1;
                  next_s.tx_next = s.sh[0];
                  next_s.kind = K_CMD;
                end
              end
              K_CMD: begin
                if (!s.busy && s.sh == CMD_MEM_ACCESS) begin
                  next_s.st = D_RX_ACK;
                  next_s.sda_oe = 1'b1;
                  next_s.kind = K_MADR;
                end
              end
              K_MADR: begin
                next_s.st = D_RX_ACK;
                next_s.sda_oe = 1'b1;
                next_s.addr = s.sh;
                next_s.base = s.sh;
                next_s.pos = '0;
                next_s.cnt = '0;
                next_s.kind = K_DATA;
              end
              K_DATA: begin
                next_s.st = D_RX_ACK;
                next_s.sda_oe = 1'b1;
                next_s.wbuf[s.pos] = s.sh;
                next_s.pos = s.pos + 1'b1;
                if (s.cnt < BUF_DEPTH) begin
                  next_s.cnt = s.cnt + ONE4;
                end
                next_s.wr_open = 1'b1;
              end
            endcase
          end
        end
        D_RX_ACK: begin
          // ack is held from the falling edge after bit 8 to the next falling edge
          if (fall) begin
            next_s.bits = '0;
            if (s.tx_next) begin
              next_s.st = D_TX;
              next_s.sh = mem_rd;
              next_s.sda_oe = !mem_rd[7];
            end else begin
              next_s.st = D_RX;
              next_s.sda_oe = 1'b0;
            end
          end
        end
        D_TX: begin
          if (rise) begin
            next_s.bits = s.bits + ONE4;
          end else if (fall) begin
            if (s.bits == BITS_PER_BYTE) begin
              next_s.sda_oe = 1'b0;
              next_s.st = D_TX_ACK;
              next_s.addr = s.addr + ADDR_STEP;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.sda_oe = !s.sh[6];
            end
          end
        end
        D_TX_ACK: begin
          if (rise) begin
            if (sda) begin
              next_s.st = D_IDLE;
            end
          end else if (fall) begin
            next_s.bits = '0;
            next_s.st = D_TX;
            next_s.sh = mem_rd;
            next_s.sda_oe = !mem_rd[7];
          end
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.dev_sda_o = 1'b0; // open drain, only ever pulls low
  assign bus.dev_sda_oe = s.sda_oe;
  assign busy_o = s.busy;
endmodule // seap_device

// [src/seap_host.sv]
`timescale 1ns/1ps
// bus master end: runs one memory write or sequential read per request
module seap_host (
  input wire logic clk_i,
  input wire logic rst_i,
  seap_bus_if.host bus,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [2:0] dev_sel_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic [3:0] len_i,
  input wire logic [15:0][7:0] wr_data_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  import seap_pkg::*;

  typedef struct packed {
    seap_hst_t st;
    seap_step_t step;
    logic [1:0] ph;
    logic [7:0] tick;
    logic [3:0] bits;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [3:0] idx;
    logic retry;
    logic busy;
    logic done;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] rd_data;
    logic rd_valid;
    logic write;
    logic [2:0] dev;
    logic [7:0] maddr;
    logic [3:0] len;
    logic [15:0][7:0] wdata;
  } seap_host_t;

  seap_host_t s;
  seap_host_t next_s;
  logic sda;
  logic qt;
  logic last;

  // ----------------------------------------------------------------
  // sda pin synchronisation
  // ----------------------------------------------------------------
  seap_sync #(
    .W(1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(bus.sda),
    .q_o(sda)
  );

  // 9-bit frame for a step: byte first, then the ack slot (1 = released)
  function automatic logic [8:0] frame(input seap_host_t h, input seap_step_t st, input logic [3:0] i,
                                       input logic lst);
    logic [8:0] f;
    f = {IDLE_BYTE, 1'b1};
    unique case (st)
      S_DEV0: f = {DEV_FAMILY, h.dev, 1'b0, 1'b1};
      S_CMD: f = {CMD_MEM_ACCESS, 1'b1};
      S_MADR: f = {h.maddr, 1'b1};
      S_WDATA: f = {h.wdata[i], 1'b1};
      S_DEV1: f = {DEV_FAMILY, h.dev, 1'b1, 1'b1};
      S_RDATA: f = {IDLE_BYTE, lst};
    endcase
    return f;
  endfunction

  // ----------------------------------------------------------------
  // sequencer, stepping once per quarter of an scl period
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rd_valid = 1'b0;
    qt = (s.tick == 8'(SCL_QTR_CYCLES - 1));
    last = ((s.idx + ONE4) == s.len);
    if (s.st != H_IDLE) begin
      next_s.tick = qt ? '0 : s.tick + 1'b1;
      if (qt) begin
        next_s.ph = s.ph + 1'b1;
      end
    end
    unique case (s.st)
      H_IDLE: begin
        if (req_i) begin
          next_s.write = write_i;
          next_s.dev = dev_sel_i;
          next_s.maddr = mem_addr_i;
          next_s.len = len_i;
          next_s.wdata = wr_data_i;
          next_s.step = S_DEV0;
          next_s.idx = '0;
          next_s.busy = 1'b1;
          next_s.st = H_START;
          next_s.ph = '0;
          next_s.tick = '0;
        end
      end
      H_START: begin
        // release sda, release scl, pull sda, pull scl; also serves as a repeated start
        if (qt) begin
          unique case (s.ph)
            2'd0: next_s.sda_oe = 1'b0;
            2'd1: next_s.scl_oe = 1'b0;
            2'd2: next_s.sda_oe = 1'b1;
            2'd3: begin
              next_s.scl_oe = 1'b1;
              next_s.st = H_BIT;
              next_s.bits = '0;
              next_s.tx = frame(s, s.step, s.idx, last);
            end
          endcase
        end
      end
      H_BIT: begin
        if (qt) begin
          unique case (s.ph)
            2'd0: next_s.sda_oe = !s.tx[8];
            2'd1: next_s.scl_oe = 1'b0;
            2'd2: next_s.rx = {s.rx[7:0], sda};
            2'd3: begin
              next_s.scl_oe = 1'b1;
              next_s.tx = {s.tx[7:0], 1'b1};
              next_s.bits = s.bits + ONE4;
              if (s.bits == BITS_PER_BYTE) begin
                next_s.bits = '0;
                unique case (s.step)
                  S_DEV0, S_CMD, S_DEV1: begin
                    if (s.rx[0]) begin
                      next_s.retry = 1'b1;
                      next_s.st = H_STOP;
                    end else begin
                      next_s.step = (s.step == S_DEV0) ? S_CMD : (s.step == S_CMD) ? S_MADR : S_RDATA;
                      next_s.idx = '0;
                      next_s.tx = frame(s, next_s.step, '0, s.len == ONE4);
                    end
                  end
                  S_MADR: begin
                    if (s.rx[0]) begin
                      next_s.retry = 1'b1;
                      next_s.st = H_STOP;
                    end else if (s.write) begin
                      next_s.step = S_WDATA;
                      next_s.tx = frame(s, S_WDATA, '0, 1'b0);
                    end else begin
                      next_s.step = S_DEV1;
                      next_s.st = H_START;
                    end
                  end
                  S_WDATA: begin
                    if (s.rx[0] || last) begin
                      next_s.st = H_STOP;
                    end else begin
                      next_s.idx = s.idx + ONE4;
                      next_s.tx = frame(s, S_WDATA, s.idx + ONE4, 1'b0);
                    end
                  end
                  S_RDATA: begin
                    next_s.rd_data = s.rx[8:1];
                    next_s.rd_valid = 1'b1;
                    if (last) begin
                      next_s.st = H_STOP;
                    end else begin
                      next_s.idx = s.idx + ONE4;
                      next_s.tx = frame(s, S_RDATA, '0, (s.idx + ONE4 + ONE4) == s.len);
                    end
                  end
                  default: next_s.st = H_STOP;
                endcase
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (qt) begin
          unique case (s.ph)
            2'd0: next_s.sda_oe = 1'b1;
            2'd1: next_s.scl_oe = 1'b0;
            2'd2: next_s.sda_oe = 1'b0;
            2'd3: begin
              if (s.retry) begin
                next_s.retry = 1'b0;
                next_s.step = S_DEV0;
                next_s.idx = '0;
                next_s.st = H_START;
              end else begin
                next_s.st = H_IDLE;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.tick = '0;
              end
            end
          endcase
        end
      end
    endcase
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = s.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = s.sda_oe;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign rd_data_o = s.rd_data;
  assign rd_valid_o = s.rd_valid;
endmodule // seap_host

// [bench/seap_checker.sv]
`timescale 1ns/1ps
// watches the shared two-wire bus, the device busy flag and the host done flag
module seap_checker #(
  parameter int unsigned PROG_CYCLES = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_sda_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic busy_o,
  input wire logic done_o
);
  import seap_pkg::*;
  // a low phase is two quarter steps; one cycle of slack on each side
  localparam int unsigned LO_MIN = 2 * SCL_QTR_CYCLES - 1;
  localparam int unsigned LO_MAX = 2 * SCL_QTR_CYCLES + 1;

  logic prev_sda;
  logic [7:0] stop_age;
  int unsigned busy_cnt;
  int unsigned lo_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // stop_age saturates so a long idle bus never wraps back into range
  always_ff @(posedge clk_i) begin
    prev_sda <= sda;
    if (rst_i || (scl && sda && !prev_sda)) begin
      stop_age <= 8'h00;
    end else if (stop_age != 8'hFF) begin
      stop_age <= stop_age + 8'h01;
    end
    busy_cnt <= (busy_o && !rst_i) ? busy_cnt + 1 : 0;
    lo_cnt <= scl ? 0 : lo_cnt + 1;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_open_drain_low: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open drain output level is high");
  a_dev_pull_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulled data while clock high");
  a_dev_release_scl_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released data while clock high");
  a_prog_after_stop: assert property ($rose(busy_o) |-> stop_age <= 8'h08)
    else $error("programming began without a stop");
  a_prog_length: assert property ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1)
    else $error("programming time is wrong");
  a_done_one_cycle: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_done_bus_idle: assert property (done_o |-> scl && sda)
    else $error("done while bus not idle");
  a_scl_low_time: assert property ($rose(scl) |-> lo_cnt >= LO_MIN && lo_cnt <= LO_MAX)
    else $error("clock low phase has wrong length");

  // main scenarios reached
  c_prog: cover property ($rose(busy_o));
  c_dev_drive: cover property ($rose(dev_sda_oe));
  c_done: cover property (done_o);
endmodule // seap_checker

// [bench/seap_tb_top.sv]
`timescale 1ns/1ps
// host and device joined on one bus; a write followed at once by a read
module seap_tb_top;
  import seap_pkg::*;
  // long enough that the command byte of the second read attempt still meets a busy device,
  // short enough that the third attempt is accepted
  localparam int unsigned PROG = 40000;
  localparam int WAIT_MAX = 100000;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] len = 4'h1;
  logic [15:0][7:0] wr_data = '0;
  logic host_busy;
  logic done;
  logic rd_valid;
  logic [7:0] rd_data;
  logic dev_busy;
  logic mon_sda = 1'b1;
  logic cs1 = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int s0;
  logic [7:0] got [$];

  always #5 clock_i = !clock_i;

  seap_bus_if i_seap_bus_if ();

  seap_host i_seap_host (.clk_i(clock_i), .rst_i(rst_i), .bus(i_seap_bus_if), .req_i(req), .write_i(wr),
    .dev_sel_i(3'h5), .mem_addr_i(addr), .len_i(len), .wr_data_i(wr_data), .busy_o(host_busy),
    .done_o(done), .rd_data_o(rd_data), .rd_valid_o(rd_valid));

  // strap 101 matches the host select above; cs1 high makes the device a stranger
  seap_device #(.PROG_CYCLES(PROG)) i_seap_device (.clk_i(clock_i), .rst_i(rst_i), .bus(i_seap_bus_if),
    .chip_select_bit0_i(1'b1), .chip_select_bit1_i(cs1), .chip_select_bit2_i(1'b1), .busy_o(dev_busy));

  seap_checker #(.PROG_CYCLES(PROG)) i_seap_checker (.clk_i(clock_i), .rst_i(rst_i),
    .scl(i_seap_bus_if.scl), .sda(i_seap_bus_if.sda), .host_scl_o(i_seap_bus_if.host_scl_o),
    .host_sda_o(i_seap_bus_if.host_sda_o), .dev_sda_o(i_seap_bus_if.dev_sda_o),
    .dev_sda_oe(i_seap_bus_if.dev_sda_oe), .busy_o(dev_busy), .done_o(done));

  // ----------------------------------------------------------------
  // bus monitor: start conditions and bytes read
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    mon_sda <= i_seap_bus_if.sda;
    if (i_seap_bus_if.scl && mon_sda && !i_seap_bus_if.sda) starts++;
    if (rd_valid === 1'b1) got.push_back(rd_data);
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
    checks++;
    if (act !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  // one request pulse, then a bounded wait for the done pulse
  task automatic run_xfer(input logic is_wr, input logic [7:0] a, input logic [3:0] n);
    int i;
    @(posedge clock_i);
    req <= 1'b1;
    wr <= is_wr;
    addr <= a;
    len <= n;
    @(posedge clock_i);
    req <= 1'b0;
    @(posedge clock_i);
    check({7'h00, host_busy}, 8'h01, "host not busy after request");
    i = 0;
    while (done !== 1'b1 && i < WAIT_MAX) begin
      @(posedge clock_i);
      i++;
    end
    if (done !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: transfer never finished", $time);
      test_done();
    end
    check({7'h00, host_busy}, 8'h00, "host still busy after done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    wr_data[0] <= 8'hA5;
    wr_data[1] <= 8'h3C;
    // write across the top of the address space
    run_xfer(1'b1, 8'hFF, 4'h2);
    check({7'h00, dev_busy}, 8'h01, "programming not started after stop");
    $display("test write ended");
    // read at once with a foreign strap: the address is refused first, then the busy
    // device refuses the command, so two retries come before the repeated start
    s0 = starts;
    got.delete();
    cs1 <= 1'b1;
    fork
      run_xfer(1'b0, 8'hFF, 4'h2);
      begin
        // match again part way through the second device address byte, before its ack
        repeat (15000) @(posedge clock_i);
        cs1 <= 1'b0;
      end
    join
    check(8'(starts - s0), 8'h04, "start count with two retries");
    check(8'(got.size()), 8'h02, "bytes read");
    check(got[0], 8'hA5, "first byte at start address");
    check(got[1], 8'h3C, "byte after address wrap");
    $display("test read ended");
    test_done();
  end
endmodule // seap_tb_top
